/* File: verilog/cmb_pkg.sv */
//
// Purpose: constants and types shared by the message buffer and sleep block
// Assumes: register index = printed offset, byte address = 4 * index
// Notes:   one 8-bit register per aligned 32-bit word, low byte lane
//
package cmb_pkg;

  // ---------------------------------------------------------------
  // bus and register map
  // ---------------------------------------------------------------
  localparam int         ADDR_W      = 9;
  localparam int         IDX_W       = 7;
  localparam int         DATA_W      = 32;
  localparam logic [6:0] IDX_CMD     = 7'h21;
  localparam logic [6:0] IDX_STAT    = 7'h22;
  localparam logic [6:0] IDX_TX_ID   = 7'h2a;
  localparam logic [6:0] IDX_TX_CTRL = 7'h2b;
  localparam logic [6:0] IDX_TX_DATA = 7'h2c;
  localparam logic [6:0] IDX_TX_LAST = 7'h33;
  localparam logic [6:0] IDX_RX_ID   = 7'h34;
  localparam logic [6:0] IDX_RX_CTRL = 7'h35;
  localparam logic [6:0] IDX_RX_DATA = 7'h36;
  localparam logic [6:0] IDX_RX_LAST = 7'h3d;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // field layout
  // ---------------------------------------------------------------
  localparam int         ID_W          = 11;
  localparam int         ID_LOW_W      = 3;
  localparam int         FC_ID_LSB     = 5;
  localparam int         FC_REMOTE_BIT = 4;
  localparam int         DLC_W         = 4;
  localparam logic [3:0] DLC_MAX       = 4'h8;
  localparam int         NUM_BYTES     = 8;
  localparam logic [3:0] ARB_BITS      = 4'hb;
  // command register bits
  localparam int CMD_LINE0_PASSIVE = 0;
  localparam int CMD_LINE1_PASSIVE = 1;
  localparam int CMD_SLEEP_SEL     = 2;
  localparam int CMD_SLEEP_REQ     = 3;
  localparam int CMD_RX_RELEASE    = 4;
  localparam int CMD_TX_REQUEST    = 5;
  // status register bits
  localparam int STAT_ASLEEP     = 0;
  localparam int STAT_WAKE       = 1;
  localparam int STAT_RX_READY   = 2;
  localparam int STAT_OVERRUN    = 3;
  localparam int STAT_ARB_LOST   = 4;
  localparam int STAT_TX_PENDING = 5;

  // ---------------------------------------------------------------
  // timing and reset values
  // ---------------------------------------------------------------
  localparam int         CLK_PERIOD_PS     = 5000;
  localparam int         STOP_DELAY_NS     = 80;
  localparam int         STOP_DELAY_CYCLES = (STOP_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [2:0] CMD_RST           = 3'h0;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {SLP_AWAKE, SLP_ASLEEP, SLP_STOP_WAIT, SLP_OSC_OFF} cmb_slp_t;

  typedef struct packed {
    logic [7:0]                           tx_id_high;
    logic [7:0]                           tx_ctrl;
    logic [NUM_BYTES-1:0][7:0]            tx_data;
    logic [1:0][7:0]                      rx_id_high;
    logic [1:0][7:0]                      rx_ctrl;
    logic [1:0][NUM_BYTES-1:0][7:0]       rx_data;
  } cmb_buf_t;

endpackage : cmb_pkg

/* File: verilog/cmb_can_buffers.sv */
//
// Purpose: can message buffers, bus value resolution, line fallback and sleep control
// Assumes: protocol engine on the same clock; bus line levels arrive as pins
// Notes:   registers over axi4-lite, one byte per word in the low lane
//
`timescale 1ns/1ps
`default_nettype none

// Operation
// - identifier is 11 bits, most significant bit leaves first in arbitration
// - smaller identifier wins arbitration
// - upper eight id bits in id register, lowest three in control bits 7..5
// - control bit 4 set sends a remote frame, clear sends a data frame
// - remote frame ignores length code and carries zero bytes
// - length code is a plain binary byte count, 0 to 8
// - payload from eight transmit byte registers, only count bytes sent in order
// - receive id and control registers share the transmit layout
// - two receive buffer sets switch internally behind one register window
// - dominant wins on simultaneous drive; dominant is 0, recessive is 1
// - a passive bit ties that receive input to the half supply reference
// - sleep request sleeps only when idle and nothing pending, else wake event
// - clearing the sleep request wakes without a wake event
// - sleep request is write-only; asleep flag shows the sleep state
// - asleep gates own clocks only; a cpu stop leaves this block clocked
// - oscillator stops only asleep and cpu stopped; wake in the delay prevents it
// - asleep uses sleep comparator; dominant level wakes and raises a wake event
// - sleep comparator uses active inputs, or each line against half supply
module cmb_can_buffers #(
  parameter int STOP_DELAY = cmb_pkg::STOP_DELAY_CYCLES
) (
  // clock, reset, clock enable
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic                        ce,
  // axi4-lite slave
  input  wire logic [cmb_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic [2:0]                  s_axi_awprot,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [cmb_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [cmb_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic [2:0]                  s_axi_arprot,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [cmb_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // bus line comparators, 0 means dominant seen on that line
  input  wire logic                        line0_in,
  input  wire logic                        line1_in,
  output logic                             line0_to_ref,
  output logic                             line1_to_ref,
  output logic                             active_cmp_en,
  output logic                             sleep_cmp_sel,
  output logic                             bus_value,
  // protocol engine, transmit side
  input  wire logic                        arb_load,
  input  wire logic                        arb_sample,
  input  wire logic [2:0]                  tx_byte_idx,
  input  wire logic                        tx_done,
  output logic [cmb_pkg::ID_W-1:0]         tx_id,
  output logic                             tx_remote,
  output logic [cmb_pkg::DLC_W-1:0]        tx_byte_count,
  output logic [7:0]                       tx_byte,
  output logic                             tx_arb_bit,
  output logic                             tx_pending,
  output logic                             arb_lost,
  // protocol engine, receive side
  input  wire logic                        rx_store,
  input  wire logic [cmb_pkg::ID_W-1:0]    rx_id,
  input  wire logic                        rx_remote,
  input  wire logic [cmb_pkg::DLC_W-1:0]   rx_dlc,
  input  wire logic [63:0]                 rx_data,
  output logic                             rx_ready,
  output logic                             rx_overrun,
  // power control
  input  wire logic                        bus_idle,
  input  wire logic                        irq_pending,
  input  wire logic                        cpu_stopped,
  output logic                             can_clk_en,
  output logic                             asleep_flag,
  output logic                             wake_event,
  output logic                             osc_stop
);
  import cmb_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic              l0_s1, l0_s2, l1_s1, l1_s2;
    logic              line0_passive, line1_passive, sleep_comparator_select;
    cmb_slp_t          slp;
    logic [7:0]        stop_cnt;
    logic              wake, asleep, osc_stop, clk_en;
    logic              vis_bank, vis_full, back_full, overrun;
    logic              tx_pending, arb_lost, arb_drive, bus_value;
    logic [ID_W-1:0]   arb_sh;
    logic [3:0]        arb_cnt;
    logic [DLC_W-1:0]  tx_count;
    logic [7:0]        tx_byte;
    logic              aw_held, w_held, w_en;
    logic [IDX_W-1:0]  aw_idx;
    logic [7:0]        w_data;
    logic              awready, wready, bvalid, arready, rvalid;
    logic [1:0]        bresp, rresp;
    logic [7:0]        rdata;
  } cmb_ctl_t;

  typedef struct packed {
    cmb_ctl_t ctl;
    cmb_buf_t bufs;
  } cmb_state_t;

  cmb_state_t st_ff;
  cmb_state_t nxt_st;

  localparam logic [7:0] STOP_LOAD = 8'(STOP_DELAY);

  // byte address to register index
  function automatic logic [IDX_W-1:0] idx_of(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2];
  endfunction : idx_of

  function automatic logic in_range(input logic [IDX_W-1:0] i, input logic [IDX_W-1:0] lo,
                                    input logic [IDX_W-1:0] hi);
    return (i >= lo) && (i <= hi);
  endfunction : in_range

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic             l0_eff;
  logic             l1_eff;
  logic             bus_val;
  logic             sleep_dom;
  logic             do_wr;
  logic [IDX_W-1:0] ar_idx;
  logic [2:0]       ar_byte;
  logic [2:0]       w_byte;

  always_comb begin
    nxt_st = st_ff;
    // status clears go first, so a hardware set later in this cycle wins
    do_wr = st_ff.ctl.aw_held && st_ff.ctl.w_held && !st_ff.ctl.bvalid;
    if (do_wr && st_ff.ctl.aw_idx == IDX_STAT && st_ff.ctl.w_en) begin
      nxt_st.ctl.wake     = st_ff.ctl.wake & ~st_ff.ctl.w_data[STAT_WAKE];
      nxt_st.ctl.overrun  = st_ff.ctl.overrun & ~st_ff.ctl.w_data[STAT_OVERRUN];
      nxt_st.ctl.arb_lost = st_ff.ctl.arb_lost & ~st_ff.ctl.w_data[STAT_ARB_LOST];
    end
    // two-stage synchronisers on the line pins
    nxt_st.ctl.l0_s1 = line0_in;
    nxt_st.ctl.l0_s2 = st_ff.ctl.l0_s1;
    nxt_st.ctl.l1_s1 = line1_in;
    nxt_st.ctl.l1_s2 = st_ff.ctl.l1_s1;

    // passive line tied to reference
    // the reference sits between levels, so a tied line never reads dominant
    l0_eff = st_ff.ctl.l0_s2 | st_ff.ctl.line0_passive;
    l1_eff = st_ff.ctl.l1_s2 | st_ff.ctl.line1_passive;
    bus_val = l0_eff & l1_eff & st_ff.ctl.arb_drive;
    nxt_st.ctl.bus_value = bus_val;
    sleep_dom = st_ff.ctl.sleep_comparator_select ? (~st_ff.ctl.l0_s2 | ~st_ff.ctl.l1_s2)
                                                   : ~(l0_eff & l1_eff);

    case (st_ff.ctl.slp)
      SLP_AWAKE: begin
      end
      SLP_ASLEEP: begin
        if (cpu_stopped) begin
          nxt_st.ctl.slp      = SLP_STOP_WAIT;
          nxt_st.ctl.stop_cnt = STOP_LOAD;
        end
      end
      SLP_STOP_WAIT: begin
        if (!cpu_stopped) begin
          nxt_st.ctl.slp = SLP_ASLEEP;
        end else if (st_ff.ctl.stop_cnt <= 8'h01) begin
          nxt_st.ctl.slp = SLP_OSC_OFF;
        end else begin
          nxt_st.ctl.stop_cnt = st_ff.ctl.stop_cnt - 8'h01;
        end
      end
      SLP_OSC_OFF: begin
        if (!cpu_stopped) begin
          nxt_st.ctl.slp = SLP_ASLEEP;
        end
      end
      default: nxt_st.ctl.slp = SLP_AWAKE;
    endcase
    if (st_ff.ctl.slp != SLP_AWAKE && sleep_dom) begin
      nxt_st.ctl.slp  = SLP_AWAKE;
      nxt_st.ctl.wake = 1'b1;
    end

    // receive: engine fills the hidden bank
    // double-buffered receive sets
    if (rx_store) begin
      if (st_ff.ctl.back_full) begin
        nxt_st.ctl.overrun = 1'b1;
      end else begin
        nxt_st.bufs.rx_id_high[~st_ff.ctl.vis_bank] = rx_id[ID_W-1:ID_LOW_W];
        nxt_st.bufs.rx_ctrl[~st_ff.ctl.vis_bank] = {rx_id[ID_LOW_W-1:0], rx_remote, rx_dlc};
        for (int i = 0; i < NUM_BYTES; i++) begin
          nxt_st.bufs.rx_data[~st_ff.ctl.vis_bank][i] = rx_data[8*i +: 8];
        end
        nxt_st.ctl.back_full = 1'b1;
      end
    end

    // transmit handshake with the engine
    if (tx_done) begin
      nxt_st.ctl.tx_pending = 1'b0;
    end

    // recessive sent but dominant seen means a lower id won
    if (arb_load) begin
      nxt_st.ctl.arb_sh  = {st_ff.bufs.tx_id_high, st_ff.bufs.tx_ctrl[7:FC_ID_LSB]};
      nxt_st.ctl.arb_cnt = ARB_BITS;
    end else if (arb_sample && st_ff.ctl.arb_cnt != 4'h0) begin
      if (st_ff.ctl.arb_drive && !bus_val) begin
        nxt_st.ctl.arb_lost = 1'b1;
        nxt_st.ctl.arb_cnt  = 4'h0;
      end else begin
        nxt_st.ctl.arb_sh  = {st_ff.ctl.arb_sh[ID_W-2:0], 1'b0};
        nxt_st.ctl.arb_cnt = st_ff.ctl.arb_cnt - 4'h1;
      end
    end

    // axi write channels, taken in either order
    if (s_axi_awvalid && st_ff.ctl.awready) begin
      nxt_st.ctl.aw_held = 1'b1;
      nxt_st.ctl.aw_idx  = idx_of(s_axi_awaddr);
    end
    if (s_axi_wvalid && st_ff.ctl.wready) begin
      nxt_st.ctl.w_held = 1'b1;
      nxt_st.ctl.w_data = s_axi_wdata[7:0];
      nxt_st.ctl.w_en   = s_axi_wstrb[0];
    end
    if (st_ff.ctl.bvalid && s_axi_bready) begin
      nxt_st.ctl.bvalid = 1'b0;
    end
    w_byte = 3'(st_ff.ctl.aw_idx - IDX_TX_DATA);
    if (do_wr) begin
      nxt_st.ctl.aw_held = 1'b0;
      nxt_st.ctl.w_held  = 1'b0;
      nxt_st.ctl.bvalid  = 1'b1;
      nxt_st.ctl.bresp   = RESP_OKAY;
      if (st_ff.ctl.aw_idx == IDX_CMD) begin
        if (st_ff.ctl.w_en) begin
          nxt_st.ctl.line0_passive           = st_ff.ctl.w_data[CMD_LINE0_PASSIVE];
          nxt_st.ctl.line1_passive           = st_ff.ctl.w_data[CMD_LINE1_PASSIVE];
          nxt_st.ctl.sleep_comparator_select = st_ff.ctl.w_data[CMD_SLEEP_SEL];
          if (st_ff.ctl.w_data[CMD_SLEEP_REQ]) begin
            if (st_ff.ctl.slp == SLP_AWAKE) begin
              if (bus_idle && !irq_pending && !sleep_dom) begin
                nxt_st.ctl.slp = SLP_ASLEEP;
              end else begin
                nxt_st.ctl.wake = 1'b1;
              end
            end
          end else begin
            nxt_st.ctl.slp = SLP_AWAKE;
          end
          if (st_ff.ctl.w_data[CMD_RX_RELEASE]) begin
            nxt_st.ctl.vis_full = 1'b0;
          end
          if (st_ff.ctl.w_data[CMD_TX_REQUEST]) begin
            nxt_st.ctl.tx_pending = 1'b1;
          end
        end
      end else if (st_ff.ctl.aw_idx == IDX_STAT) begin
        // write one to clear, applied at the top of this process
      end else if (st_ff.ctl.aw_idx == IDX_TX_ID) begin
        if (st_ff.ctl.w_en) begin
          nxt_st.bufs.tx_id_high = st_ff.ctl.w_data;
        end
      end else if (st_ff.ctl.aw_idx == IDX_TX_CTRL) begin
        if (st_ff.ctl.w_en) begin
          nxt_st.bufs.tx_ctrl = st_ff.ctl.w_data;
        end
      end else if (in_range(st_ff.ctl.aw_idx, IDX_TX_DATA, IDX_TX_LAST)) begin
        if (st_ff.ctl.w_en) begin
          nxt_st.bufs.tx_data[w_byte] = st_ff.ctl.w_data;
        end
      end else begin
        // receive window is read-only; anything else is unmapped
        nxt_st.ctl.bresp = RESP_SLVERR;
      end
    end
    nxt_st.ctl.awready = !nxt_st.ctl.aw_held && !nxt_st.ctl.bvalid;
    nxt_st.ctl.wready  = !nxt_st.ctl.w_held && !nxt_st.ctl.bvalid;

    // present a new frame once the visible bank is released
    if (nxt_st.ctl.back_full && !nxt_st.ctl.vis_full) begin
      nxt_st.ctl.vis_bank  = ~st_ff.ctl.vis_bank;
      nxt_st.ctl.vis_full  = 1'b1;
      nxt_st.ctl.back_full = 1'b0;
    end

    // axi read channel
    ar_idx  = idx_of(s_axi_araddr);
    ar_byte = 3'(ar_idx - IDX_RX_DATA);
    if (st_ff.ctl.rvalid && s_axi_rready) begin
      nxt_st.ctl.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_ff.ctl.arready) begin
      nxt_st.ctl.rvalid = 1'b1;
      nxt_st.ctl.rresp  = RESP_OKAY;
      nxt_st.ctl.rdata  = 8'h00;
      if (ar_idx == IDX_CMD) begin
        // sleep request reads back as zero
        nxt_st.ctl.rdata[CMD_LINE0_PASSIVE] = st_ff.ctl.line0_passive;
        nxt_st.ctl.rdata[CMD_LINE1_PASSIVE] = st_ff.ctl.line1_passive;
        nxt_st.ctl.rdata[CMD_SLEEP_SEL]     = st_ff.ctl.sleep_comparator_select;
      end else if (ar_idx == IDX_STAT) begin
        nxt_st.ctl.rdata[STAT_ASLEEP]     = st_ff.ctl.asleep;
        nxt_st.ctl.rdata[STAT_WAKE]       = st_ff.ctl.wake;
        nxt_st.ctl.rdata[STAT_RX_READY]   = st_ff.ctl.vis_full;
        nxt_st.ctl.rdata[STAT_OVERRUN]    = st_ff.ctl.overrun;
        nxt_st.ctl.rdata[STAT_ARB_LOST]   = st_ff.ctl.arb_lost;
        nxt_st.ctl.rdata[STAT_TX_PENDING] = st_ff.ctl.tx_pending;
      end else if (ar_idx == IDX_TX_ID) begin
        nxt_st.ctl.rdata = st_ff.bufs.tx_id_high;
      end else if (ar_idx == IDX_TX_CTRL) begin
        nxt_st.ctl.rdata = st_ff.bufs.tx_ctrl;
      end else if (in_range(ar_idx, IDX_TX_DATA, IDX_TX_LAST)) begin
        nxt_st.ctl.rdata = st_ff.bufs.tx_data[3'(ar_idx - IDX_TX_DATA)];
      end else if (ar_idx == IDX_RX_ID) begin
        nxt_st.ctl.rdata = st_ff.bufs.rx_id_high[st_ff.ctl.vis_bank];
      end else if (ar_idx == IDX_RX_CTRL) begin
        nxt_st.ctl.rdata = st_ff.bufs.rx_ctrl[st_ff.ctl.vis_bank];
      end else if (in_range(ar_idx, IDX_RX_DATA, IDX_RX_LAST)) begin
        nxt_st.ctl.rdata = st_ff.bufs.rx_data[st_ff.ctl.vis_bank][ar_byte];
      end else begin
        nxt_st.ctl.rresp = RESP_SLVERR;
      end
    end
    nxt_st.ctl.arready = !nxt_st.ctl.rvalid;

    // derived registered outputs
    // only this block's clock is gated; cpu stop only changes osc_stop
    nxt_st.ctl.asleep   = nxt_st.ctl.slp != SLP_AWAKE;
    nxt_st.ctl.clk_en   = nxt_st.ctl.slp == SLP_AWAKE;
    nxt_st.ctl.osc_stop = nxt_st.ctl.slp == SLP_OSC_OFF;
    nxt_st.ctl.arb_drive = (nxt_st.ctl.arb_cnt != 4'h0) ? nxt_st.ctl.arb_sh[ID_W-1] : 1'b1;
    // binary count, codes above eight clamp to eight
    if (nxt_st.bufs.tx_ctrl[FC_REMOTE_BIT]) begin
      nxt_st.ctl.tx_count = 4'h0;
    end else if (nxt_st.bufs.tx_ctrl[DLC_W-1:0] > DLC_MAX) begin
      nxt_st.ctl.tx_count = DLC_MAX;
    end else begin
      nxt_st.ctl.tx_count = nxt_st.bufs.tx_ctrl[DLC_W-1:0];
    end
    // payload byte by index, engine stops at the count
    nxt_st.ctl.tx_byte = st_ff.bufs.tx_data[tx_byte_idx];
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // buffers keep contents through sleep and are not reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff.ctl <= '0;
      st_ff.ctl.line0_passive <= CMD_RST[CMD_LINE0_PASSIVE];
      st_ff.ctl.line1_passive <= CMD_RST[CMD_LINE1_PASSIVE];
      st_ff.ctl.sleep_comparator_select <= CMD_RST[CMD_SLEEP_SEL];
      st_ff.ctl.slp       <= SLP_AWAKE;
      st_ff.ctl.clk_en    <= 1'b1;
      st_ff.ctl.arb_drive <= 1'b1;
      st_ff.ctl.bus_value <= 1'b1;
      st_ff.ctl.awready   <= 1'b1;
      st_ff.ctl.wready    <= 1'b1;
      st_ff.ctl.arready   <= 1'b1;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign s_axi_awready = st_ff.ctl.awready;
  assign s_axi_wready  = st_ff.ctl.wready;
  assign s_axi_bresp   = st_ff.ctl.bresp;
  assign s_axi_bvalid  = st_ff.ctl.bvalid;
  assign s_axi_arready = st_ff.ctl.arready;
  assign s_axi_rdata   = {24'h00_0000, st_ff.ctl.rdata};
  assign s_axi_rresp   = st_ff.ctl.rresp;
  assign s_axi_rvalid  = st_ff.ctl.rvalid;
  assign line0_to_ref  = st_ff.ctl.line0_passive;
  assign line1_to_ref  = st_ff.ctl.line1_passive;
  assign active_cmp_en = st_ff.ctl.clk_en;
  assign sleep_cmp_sel = st_ff.ctl.sleep_comparator_select;
  assign bus_value     = st_ff.ctl.bus_value;
  assign tx_id         = {st_ff.bufs.tx_id_high, st_ff.bufs.tx_ctrl[7:FC_ID_LSB]};
  assign tx_remote     = st_ff.bufs.tx_ctrl[FC_REMOTE_BIT];
  assign tx_byte_count = st_ff.ctl.tx_count;
  assign tx_byte       = st_ff.ctl.tx_byte;
  assign tx_arb_bit    = st_ff.ctl.arb_drive;
  assign tx_pending    = st_ff.ctl.tx_pending;
  assign arb_lost      = st_ff.ctl.arb_lost;
  assign rx_ready      = st_ff.ctl.vis_full;
  assign rx_overrun    = st_ff.ctl.overrun;
  assign can_clk_en    = st_ff.ctl.clk_en;
  assign asleep_flag   = st_ff.ctl.asleep;
  assign wake_event    = st_ff.ctl.wake;
  assign osc_stop      = st_ff.ctl.osc_stop;

endmodule : cmb_can_buffers

`default_nettype wire

/* File: testbench/cmb_peer_node.sv */
// Purpose: far node  Assumes: one drive feeds both lines  Notes: idle lines sit recessive
`timescale 1ns/1ps
`default_nettype none
module cmb_peer_node (
  input  wire logic send_dom,
  output logic      line0_in,
  output logic      line1_in
);
  assign line0_in = ~send_dom;
  assign line1_in = ~send_dom;
endmodule : cmb_peer_node
`default_nettype wire

/* File: testbench/cmb_can_buffers_sva.sv */
// Purpose: port checker  Assumes: one clock domain  Notes: bound below
`timescale 1ns/1ps
`default_nettype none
module cmb_chk (
  input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid,
  input wire logic tx_remote, tx_arb_bit, bus_value, asleep_flag, can_clk_en, active_cmp_en, osc_stop,
  input wire logic cpu_stopped, bus_idle, irq_pending, line0_in, line1_in,
  input wire logic [3:0] tx_byte_count
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_REMOTE_ZERO: assert property (tx_remote |-> tx_byte_count == 4'h0) else $error("remote count");
  AST_COUNT_MAX: assert property (!tx_remote |-> tx_byte_count <= 4'h8) else $error("count range");
  AST_DOMINANT: assert property (!tx_arb_bit |-> ##[0:2] !bus_value) else $error("bus not dominant");
  AST_ASLEEP_CLK: assert property (asleep_flag |-> !can_clk_en && !active_cmp_en) else $error("clock on");
  AST_OSC: assert property (osc_stop |-> $past(asleep_flag) && $past(cpu_stopped)) else $error("osc stop");
  AST_WAKE_DOM: assert property (asleep_flag && !line0_in && !line1_in |-> ##[1:6] !asleep_flag)
    else $error("no wake");
  AST_SLEEP_GUARD: assert property ($rose(asleep_flag) |-> $past(bus_idle) && !$past(irq_pending))
    else $error("bad sleep");
  AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("late write");
endmodule : cmb_chk
bind cmb_can_buffers cmb_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .tx_remote, .tx_arb_bit, .bus_value, .asleep_flag, .can_clk_en, .active_cmp_en, .osc_stop,
  .cpu_stopped, .bus_idle, .irq_pending, .line0_in, .line1_in, .tx_byte_count);
`default_nettype wire

/* File: testbench/test_can_message_buffers_sleep.sv */
// Purpose: self-checking bench  Assumes: ce high  Notes: stop delay shortened to 2
`timescale 1ns/1ps
`default_nettype none
module test_can_message_buffers_sleep;
  import cmb_pkg::*;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, dom = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, line0_in, line1_in;
  logic arb_load = 0, arb_sample = 0, rx_store = 0, rx_remote = 0, bus_idle = 1, irq_pending = 0, cpu_stopped = 0;
  logic tx_remote, tx_arb_bit, rx_ready, asleep_flag, wake_event, osc_stop, line0_to_ref, tx_pending, tx_done = 0;
  logic [8:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, lfsr = 32'hc2d0;
  logic [1:0] s_axi_bresp, s_axi_rresp, bv;
  logic [2:0] tx_byte_idx = 0;
  logic [3:0] rx_dlc = 0, tx_byte_count;
  logic [10:0] rx_id = 0, tx_id, e;
  logic [7:0] tx_byte, h, c, pay [8];
  logic [63:0] rx_data = 0;
  logic [33:0] rv;
  int error_cnt = 0, n_tests = 0, cyc = 0, rxq[$];
  cmb_can_buffers #(.STOP_DELAY(2)) DUT (.*, .ce(1'b1), .s_axi_awprot(3'h0), .s_axi_wstrb(4'hf), .s_axi_arprot(3'h0),
    .line1_to_ref(), .active_cmp_en(), .sleep_cmp_sel(), .bus_value(), .arb_lost(),
    .rx_overrun(), .can_clk_en());
  cmb_peer_node peer (.send_dom(dom), .line0_in, .line1_in);
  always #2.5 aclk = ~aclk;
  task automatic chk(input string n, input logic [33:0] x, input logic [33:0] g);
    n_tests++;
    if (g !== x) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic wr(input logic [6:0] i, input logic [7:0] d);
    {s_axi_awaddr, s_axi_wdata} <= {i, 2'b00, 24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    bv = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [6:0] i);
    s_axi_araddr <= {i, 2'b00};
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    rv = {s_axi_rresp, s_axi_rdata};
  endtask : rd
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  always @(posedge aclk) if (++cyc == 20000) begin
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    for (int k = 0; k < 18; k++) begin
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      h = {1'b0, lfsr[6:0]};
      c = {lfsr[10:8], 1'(k / 9), 4'(k % 9)};
      wr(IDX_TX_ID, h);
      wr(IDX_TX_CTRL, c);
      chk("tx_id", 34'({h, c[7:5]}), 34'(tx_id));
      chk("tx_kind", 34'({c[4], c[4] ? 4'h0 : c[3:0]}), 34'({tx_remote, tx_byte_count}));
      rd(IDX_TX_CTRL);
      chk("tx_ctrl_rd", {RESP_OKAY, 24'h0, c}, rv);
    end
    for (int k = 0; k < 8; k++) begin
      pay[k] = lfsr[7 + k -: 8];
      wr(7'(IDX_TX_DATA + k), pay[k]);
    end
    for (int k = 0; k < 8; k++) begin
      tx_byte_idx <= 3'(k);
      repeat (2) @(posedge aclk);
      chk("tx_byte", 34'(pay[k]), 34'(tx_byte));
    end
    e = {h, c[7:5]};
    bus_idle <= 0;
    arb_load <= 1;
    @(posedge aclk);
    arb_load <= 0;
    for (int k = 10; k >= 0; k--) begin
      repeat (2) @(posedge aclk);
      chk("arb_bit", 34'(e[k]), 34'(tx_arb_bit));
      arb_sample <= 1;
      @(posedge aclk);
      arb_sample <= 0;
    end
    bus_idle <= 1;
    rx_store <= 1;
    for (int k = 0; k < 2; k++) begin
      rxq.push_back(int'(lfsr[21 + k -: 22]));
      {rx_dlc, rx_id, rx_data[7:0]} <= {1'b0, lfsr[21 + k -: 22]};
      @(posedge aclk);
    end
    rx_store <= 0;
    for (int k = 0; k < 2; k++) begin
      @(posedge aclk);
      chk("rx_ready", 34'h1, 34'(rx_ready));
      rd(IDX_RX_CTRL);
      chk("rx_ctrl", {RESP_OKAY, 24'h0, rxq[0][10:8], 1'b0, 1'b0, rxq[0][21:19]}, rv);
      rd(IDX_RX_DATA);
      chk("rx_byte", {RESP_OKAY, 24'h0, rxq[0][7:0]}, rv);
      void'(rxq.pop_front());
      wr(IDX_CMD, 8'h10);
    end
    wr(IDX_CMD, 8'h20);
    chk("tx_pending", 34'h1, 34'(tx_pending));
    tx_done <= 1;
    @(posedge aclk);
    tx_done <= 0;
    @(posedge aclk);
    chk("tx_cleared", 34'h0, 34'(tx_pending));
    wr(IDX_RX_ID, 8'h55);
    rd(7'h7f);
    chk("wr_refused", 34'(RESP_SLVERR), 34'(bv));
    chk("rd_refused", {RESP_SLVERR, 32'h0}, rv);
    wr(IDX_CMD, 8'h08);
    repeat (2) @(posedge aclk);
    rd(IDX_CMD);
    chk("sleep_rd", 34'h2, 34'({asleep_flag, rv[3]}));
    cpu_stopped <= 1;
    repeat (6) @(posedge aclk);
    chk("osc_stop", 34'h1, 34'(osc_stop));
    dom <= 1;
    repeat (8) @(posedge aclk);
    chk("dom_wake", 34'h2, 34'({wake_event, asleep_flag}));
    {dom, cpu_stopped, irq_pending} <= 3'h1;
    wr(IDX_STAT, 8'h02);
    wr(IDX_CMD, 8'h08);
    repeat (2) @(posedge aclk);
    chk("busy_sleep", 34'h2, 34'({wake_event, asleep_flag}));
    irq_pending <= 0;
    wr(IDX_STAT, 8'h02);
    wr(IDX_CMD, 8'h08);
    wr(IDX_CMD, 8'h01);
    chk("quiet_wake", 34'h4, 34'({line0_to_ref, wake_event, asleep_flag}));
    conclude();
  end
endmodule : test_can_message_buffers_sleep
`default_nettype wire
